// ---- include/utb_map.svh ----
// Purpose: Register indexes, field positions, reset values and timing counts
// Assumes: Byte address of a register is four times its index
// Notes: Definitions only
`ifndef UTB_MAP_SVH
`define UTB_MAP_SVH

`define UTB_IDX_TIMER2_CONTROL 12'h418
`define UTB_IDX_TIMER2_MODE 12'h419
`define UTB_IDX_SYSTEM_CONFIG 12'h440
`define UTB_IDX_SCTL0 12'h420
`define UTB_IDX_SBUF0 12'h421
`define UTB_IDX_SCTL1 12'h424
`define UTB_IDX_SBUF1 12'h425
`define UTB_IDX_T1_RELOAD 12'h430
`define UTB_IDX_T1_MODE 12'h431
`define UTB_IDX_T2_RELOAD 12'h432

`define UTB_RX_T2_BIT 5
`define UTB_TX_T2_BIT 4
`define UTB_T2_RUN_BIT 2
`define UTB_PRESC_HI_BIT 3
`define UTB_PRESC_LO_BIT 2
`define UTB_T1_MODE8_BIT 0
`define UTB_T1_RUN_BIT 1

`define UTB_MODE_HI_BIT 7
`define UTB_MODE_LO_BIT 6
`define UTB_RX_EN_BIT 4
`define UTB_TX_NINTH_BIT 3
`define UTB_RX_NINTH_BIT 2
`define UTB_TX_DONE_BIT 1
`define UTB_RX_DONE_BIT 0

`define UTB_RST_BYTE 8'h00
`define UTB_RST_WORD 16'h0000

`define UTB_SUB_LAST 4'hf
`define UTB_SUB_MID 4'h7
`define UTB_SUB_HALF 4'h8
`define UTB_PRESC4_LAST 6'h03
`define UTB_PRESC16_LAST 6'h0f
`define UTB_PRESC64_LAST 6'h3f
`define UTB_T8_LAST 8'hff
`define UTB_T16_LAST 16'hffff

`endif

// ---- include/utb_pkg.sv ----
// Purpose: Types shared by the serial transmit and baud logic
// Assumes: Constants live in utb_map.svh
// Notes: States are one-hot
package utb_pkg;

    typedef enum logic [1:0] {
        UTB_MODE_SHIFT = 2'b00,
        UTB_MODE_8BIT = 2'b01,
        UTB_MODE_9FIX = 2'b10,
        UTB_MODE_9VAR = 2'b11
    } utb_mode_t;

    typedef enum logic [1:0] {
        UTB_IDLE = 2'b01,
        UTB_SHIFT = 2'b10
    } utb_st_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic ovf;
    } utb_tmr_t;

    typedef struct packed {
        utb_st_t tst;
        logic hold_full;
        logic [7:0] hold;
        logic [7:0] shift;
        logic [3:0] idx;
        logic [3:0] sub;
        logic tx_idle;
        logic tx_done;
        logic txd;
        logic dout;
        logic doe_n;
        utb_st_t rst;
        logic [3:0] ridx;
        logic [3:0] rsub;
        logic [9:0] rsh;
        logic [7:0] rdata;
        logic rninth;
        logic rx_done;
    } utb_port_t;

    typedef struct packed {
        logic [1:0][7:0] sctl;
        logic [7:0] t2ctl;
        logic [7:0] timer2_mode;
        logic [7:0] syscfg;
        logic [15:0] t1_reload;
        logic [7:0] t1_mode;
        logic [15:0] t2_reload;
        logic [5:0] presc;
        logic half;
        logic [1:0] rx_meta;
        logic [1:0] rx_sync;
        logic [1:0] load;
        logic [1:0][7:0] ldata;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } utb_top_t;

endpackage : utb_pkg

// ---- design/utb_timer.sv ----
// Purpose: Up counter with reload that pulses on overflow, used as baud source
// Assumes: tick_in is a one-cycle prescaler pulse
// Notes: Held at its reload value while stopped
`timescale 1ns/1ps
`include "utb_map.svh"
module utb_timer
    import utb_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic tick_in,
    input wire logic run_in,
    input wire logic mode8_in,
    input wire logic [15:0] reload_in,
    output logic ovf_out
);
    utb_tmr_t s, n;

    always_comb begin
        n = s;
        n.ovf = 1'b0;
        if (!run_in) begin
            n.cnt = reload_in;
        end else if (tick_in) begin
            // Overflow period is range minus reload prescaled ticks
            if (mode8_in && s.cnt[7:0] == `UTB_T8_LAST) begin
                n.cnt = {8'h00, reload_in[7:0]};
                n.ovf = 1'b1;
            end else if (!mode8_in && s.cnt == `UTB_T16_LAST) begin
                n.cnt = reload_in;
                n.ovf = 1'b1;
            end else begin
                n.cnt = s.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign ovf_out = s.ovf;
endmodule : utb_timer

// ---- design/utb_port.sv ----
// Purpose: One serial port: double buffered transmitter and framed receiver
// Assumes: Ticks are one-cycle pulses at sixteen times the bit rate
// Notes: Shift mode receive is not supported
`timescale 1ns/1ps
`include "utb_map.svh"
module utb_port
    import utb_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [1:0] mode_in,
    input wire logic tx_tick_in,
    input wire logic rx_tick_in,
    input wire logic load_in,
    input wire logic [7:0] load_data_in,
    input wire logic tx_ninth_in,
    input wire logic rx_enable_in,
    input wire logic rx_pin_sync_in,
    output logic tx_idle_out,
    output logic tx_done_out,
    output logic rx_done_out,
    output logic [7:0] rx_data_out,
    output logic rx_ninth_out,
    output logic tx_pin_out,
    output logic rx_pin_out,
    output logic rx_pin_oe_n_out
);
    utb_port_t s, n;
    logic nine;
    logic take;

    function automatic logic [3:0] last_idx(input logic [1:0] m);
        unique case (m)
            UTB_MODE_SHIFT: last_idx = 4'h7;
            UTB_MODE_8BIT: last_idx = 4'h9;
            default: last_idx = 4'ha;
        endcase
    endfunction : last_idx

    // Ninth bit comes live from the control bit, not from the byte
    function automatic logic bit_val(input logic [3:0] idx, input logic [7:0] d,
                                     input logic ninth, input logic nine9);
        if (idx == 4'h0) begin
            bit_val = 1'b0;
        end else if (idx <= 4'h8) begin
            bit_val = d[3'(idx - 4'h1)];
        end else if (idx == 4'h9 && nine9) begin
            bit_val = ninth;
        end else begin
            bit_val = 1'b1;
        end
    endfunction : bit_val

    always_comb begin
        n = s;
        n.tx_done = 1'b0;
        n.rx_done = 1'b0;
        nine = mode_in[1];
        take = 1'b0;
        unique case (s.tst)
            UTB_IDLE: begin
                take = s.hold_full;
            end
            UTB_SHIFT: begin
                if (tx_tick_in) begin
                    n.sub = s.sub + 4'h1;
                    if (s.sub == `UTB_SUB_LAST) begin
                        if (s.idx == last_idx(mode_in)) begin
                            n.tx_done = 1'b1;
                            take = s.hold_full;
                            if (!s.hold_full) begin
                                n.tst = UTB_IDLE;
                            end
                        end else begin
                            n.idx = s.idx + 4'h1;
                        end
                    end
                end
            end
        endcase
        if (take) begin
            n.tst = UTB_SHIFT;
            n.shift = s.hold;
            n.hold_full = 1'b0;
            n.idx = 4'h0;
            n.sub = 4'h0;
        end
        if (load_in) begin
            n.hold = load_data_in;
            n.hold_full = 1'b1;
        end
        n.tx_idle = (n.tst == UTB_IDLE) && !n.hold_full;
        if (n.tst == UTB_SHIFT && mode_in == UTB_MODE_SHIFT) begin
            // Shift clock low for the first half of each bit
            n.txd = (n.sub >= `UTB_SUB_HALF);
            n.dout = n.shift[n.idx[2:0]];
            n.doe_n = 1'b0;
        end else begin
            n.txd = (n.tst == UTB_SHIFT) ? bit_val(n.idx, n.shift, tx_ninth_in, nine) : 1'b1;
            n.dout = 1'b1;
            n.doe_n = 1'b1;
        end

        unique case (s.rst)
            UTB_IDLE: begin
                if (rx_tick_in && rx_enable_in && mode_in != UTB_MODE_SHIFT && !rx_pin_sync_in) begin
                    n.rst = UTB_SHIFT;
                    n.ridx = 4'h0;
                    n.rsub = 4'h0;
                end
            end
            UTB_SHIFT: begin
                if (rx_tick_in) begin
                    n.rsub = s.rsub + 4'h1;
                    if (s.rsub == `UTB_SUB_MID) begin
                        n.ridx = s.ridx + 4'h1;
                        if (s.ridx == 4'h0) begin
                            // A start bit gone high again was noise
                            if (rx_pin_sync_in) begin
                                n.rst = UTB_IDLE;
                            end
                        end else begin
                            n.rsh = {rx_pin_sync_in, s.rsh[9:1]};
                            if (s.ridx == last_idx(mode_in)) begin
                                n.rst = UTB_IDLE;
                                n.rx_done = 1'b1;
                                n.rdata = nine ? n.rsh[7:0] : n.rsh[8:1];
                                n.rninth = nine ? n.rsh[8] : n.rsh[9];
                            end
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s <= '{tst: UTB_IDLE, rst: UTB_IDLE, tx_idle: 1'b1, txd: 1'b1, dout: 1'b1,
                   doe_n: 1'b1, default: '0};
        end else begin
            s <= n;
        end
    end

    assign tx_idle_out = s.tx_idle;
    assign tx_done_out = s.tx_done;
    assign rx_done_out = s.rx_done;
    assign rx_data_out = s.rdata;
    assign rx_ninth_out = s.rninth;
    assign tx_pin_out = s.txd;
    assign rx_pin_out = s.dout;
    assign rx_pin_oe_n_out = s.doe_n;
endmodule : utb_port

// ---- design/utb_top.sv ----
// Purpose: Two serial ports with transmit flags, baud generation and APB registers
// Assumes: 125 MHz clk_in is the oscillator; serial rx pins are asynchronous
// Notes: Zero wait state APB slave; unmapped addresses answer with pslverr
`timescale 1ns/1ps
`include "utb_map.svh"
module utb_top
    import utb_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [13:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [1:0] serial_rx_pin_in,
    output logic [1:0] serial_rx_pin_out,
    output logic [1:0] serial_rx_pin_oe_n_out,
    output logic [1:0] serial_tx_pin_out
);
    utb_top_t s, n;
    logic t1_tick, t2_tick, t1_ovf, t2_ovf;
    logic [1:0] tx_tick, rx_tick, tx_idle, tx_done, rx_done, rx_ninth;
    logic [1:0][7:0] rx_data;
    logic [11:0] idx;
    logic access;

    function automatic logic presc_tick(input logic [1:0] code, input logic [5:0] cnt);
        unique case (code)
            2'b00: presc_tick = (cnt[1:0] == 2'(`UTB_PRESC4_LAST));
            2'b01: presc_tick = (cnt[3:0] == 4'(`UTB_PRESC16_LAST));
            2'b10: presc_tick = (cnt == `UTB_PRESC64_LAST);
            default: presc_tick = 1'b0; // Reserved code stops the timers
        endcase
    endfunction : presc_tick

    function automatic logic baud_tick(input logic [1:0] mode, input logic t2sel,
                                       input logic ovf1, input logic ovf2, input logic half);
        unique case (mode)
            UTB_MODE_SHIFT: baud_tick = 1'b1;
            UTB_MODE_9FIX: baud_tick = half;
            default: baud_tick = t2sel ? ovf2 : ovf1;
        endcase
    endfunction : baud_tick

    function automatic logic [32:0] read_reg(input logic [11:0] i, input utb_top_t r,
                                             input logic [1:0][7:0] rxd);
        read_reg = {1'b1, 32'h0000_0000};
        unique case (i)
            `UTB_IDX_TIMER2_CONTROL: read_reg[7:0] = r.t2ctl;
            `UTB_IDX_TIMER2_MODE: read_reg[7:0] = r.timer2_mode;
            `UTB_IDX_SYSTEM_CONFIG: read_reg[7:0] = r.syscfg;
            `UTB_IDX_SCTL0: read_reg[7:0] = r.sctl[0];
            `UTB_IDX_SBUF0: read_reg[7:0] = rxd[0];
            `UTB_IDX_SCTL1: read_reg[7:0] = r.sctl[1];
            `UTB_IDX_SBUF1: read_reg[7:0] = rxd[1];
            `UTB_IDX_T1_RELOAD: read_reg[15:0] = r.t1_reload;
            `UTB_IDX_T1_MODE: read_reg[7:0] = r.t1_mode;
            `UTB_IDX_T2_RELOAD: read_reg[15:0] = r.t2_reload;
            default: read_reg[32] = 1'b0;
        endcase
    endfunction : read_reg

    assign idx = paddr_in[13:2];
    assign access = psel_in && penable_in && s.pready;
    assign t1_tick = presc_tick(s.syscfg[`UTB_PRESC_HI_BIT:`UTB_PRESC_LO_BIT], s.presc);
    assign t2_tick = t1_tick;

    always_comb begin
        n = s;
        n.load = 2'b00;
        n.presc = s.presc + 6'h01;
        n.half = ~s.half;
        n.rx_meta = serial_rx_pin_in;
        n.rx_sync = s.rx_meta;
        n.pready = psel_in && !penable_in;
        n.pslverr = 1'b0;
        if (psel_in && !penable_in) begin
            {n.pslverr, n.prdata} = read_reg(idx, s, rx_data);
            n.pslverr = ~n.pslverr;
        end
        if (access && pwrite_in && !s.pslverr) begin
            unique case (idx)
                `UTB_IDX_TIMER2_CONTROL: n.t2ctl = pwdata_in[7:0];
                `UTB_IDX_TIMER2_MODE: n.timer2_mode = pwdata_in[7:0];
                `UTB_IDX_SYSTEM_CONFIG: n.syscfg = pwdata_in[7:0];
                `UTB_IDX_SCTL0: n.sctl[0] = pwdata_in[7:0];
                `UTB_IDX_SCTL1: n.sctl[1] = pwdata_in[7:0];
                `UTB_IDX_SBUF0: begin
                    n.load[0] = 1'b1;
                    n.ldata[0] = pwdata_in[7:0];
                end
                `UTB_IDX_SBUF1: begin
                    n.load[1] = 1'b1;
                    n.ldata[1] = pwdata_in[7:0];
                end
                `UTB_IDX_T1_RELOAD: n.t1_reload = pwdata_in[15:0];
                `UTB_IDX_T1_MODE: n.t1_mode = pwdata_in[7:0];
                `UTB_IDX_T2_RELOAD: n.t2_reload = pwdata_in[15:0];
                default: n.load = 2'b00;
            endcase
        end
        // Hardware sets applied after the software write so a set wins
        for (int p = 0; p < 2; p++) begin
            if (tx_done[p]) begin
                n.sctl[p][`UTB_TX_DONE_BIT] = 1'b1;
            end
            if (n.load[p] && tx_idle[p]) begin
                n.sctl[p][`UTB_TX_DONE_BIT] = 1'b1;
            end
            if (rx_done[p]) begin
                n.sctl[p][`UTB_RX_DONE_BIT] = 1'b1;
                n.sctl[p][`UTB_RX_NINTH_BIT] = rx_ninth[p];
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s <= '{rx_meta: 2'b11, rx_sync: 2'b11, t1_reload: `UTB_RST_WORD, t2_reload: `UTB_RST_WORD,
                   t2ctl: `UTB_RST_BYTE, timer2_mode: `UTB_RST_BYTE, syscfg: `UTB_RST_BYTE, default: '0};
        end else begin
            s <= n;
        end
    end

    utb_timer u_timer1 (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .tick_in(t1_tick),
        .run_in(s.t1_mode[`UTB_T1_RUN_BIT]),
        .mode8_in(s.t1_mode[`UTB_T1_MODE8_BIT]),
        .reload_in(s.t1_reload),
        .ovf_out(t1_ovf)
    );

    utb_timer u_timer2 (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .tick_in(t2_tick),
        .run_in(s.t2ctl[`UTB_T2_RUN_BIT]),
        .mode8_in(1'b0),
        .reload_in(s.t2_reload),
        .ovf_out(t2_ovf)
    );

    always_comb begin
        tx_tick[0] = baud_tick(s.sctl[0][7:6], s.t2ctl[`UTB_TX_T2_BIT], t1_ovf, t2_ovf, s.half);
        rx_tick[0] = baud_tick(s.sctl[0][7:6], s.t2ctl[`UTB_RX_T2_BIT], t1_ovf, t2_ovf, s.half);
        tx_tick[1] = baud_tick(s.sctl[1][7:6], s.timer2_mode[`UTB_TX_T2_BIT], t1_ovf, t2_ovf, s.half);
        rx_tick[1] = baud_tick(s.sctl[1][7:6], s.timer2_mode[`UTB_RX_T2_BIT], t1_ovf, t2_ovf, s.half);
    end

    for (genvar p = 0; p < 2; p++) begin : g_port
        utb_port u_port (
            .clk_in(clk_in),
            .reset_n_in(reset_n_in),
            .mode_in(s.sctl[p][`UTB_MODE_HI_BIT:`UTB_MODE_LO_BIT]),
            .tx_tick_in(tx_tick[p]),
            .rx_tick_in(rx_tick[p]),
            .load_in(s.load[p]),
            .load_data_in(s.ldata[p]),
            .tx_ninth_in(s.sctl[p][`UTB_TX_NINTH_BIT]),
            .rx_enable_in(s.sctl[p][`UTB_RX_EN_BIT]),
            .rx_pin_sync_in(s.rx_sync[p]),
            .tx_idle_out(tx_idle[p]),
            .tx_done_out(tx_done[p]),
            .rx_done_out(rx_done[p]),
            .rx_data_out(rx_data[p]),
            .rx_ninth_out(rx_ninth[p]),
            .tx_pin_out(serial_tx_pin_out[p]),
            .rx_pin_out(serial_rx_pin_out[p]),
            .rx_pin_oe_n_out(serial_rx_pin_oe_n_out[p])
        );
    end

    assign prdata_out = s.prdata;
    assign pready_out = s.pready;
    assign pslverr_out = s.pslverr;
endmodule : utb_top

// ---- verification/utb_top_assertions.sv ----
// Purpose: Bus and shift pin checks
// Assumes: Shift clock low in first half of a bit
// Notes: Port 0 pins only; port 1 is the same logic
`timescale 1ns/1ps
`include "utb_map.svh"
module utb_top_assertions (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [13:0] paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic [1:0] serial_rx_pin_out,
    input wire logic [1:0] serial_rx_pin_oe_n_out,
    input wire logic [1:0] serial_tx_pin_out
);
    logic [11:0] idx;
    logic mapped;
    assign idx = paddr_in[13:2];
    assign mapped = idx inside {`UTB_IDX_TIMER2_CONTROL, `UTB_IDX_TIMER2_MODE, `UTB_IDX_SYSTEM_CONFIG,
        `UTB_IDX_SCTL0, `UTB_IDX_SBUF0, `UTB_IDX_SCTL1, `UTB_IDX_SBUF1, `UTB_IDX_T1_RELOAD,
        `UTB_IDX_T1_MODE, `UTB_IDX_T2_RELOAD};
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    sequence setup_s;
        psel_in && !penable_in;
    endsequence
    sequence shift_bit_s;
        !serial_tx_pin_out[0] [*8] ##1 serial_tx_pin_out[0] [*8];
    endsequence
    sequence data_hold_s;
        $stable(serial_rx_pin_out[0]) [*8];
    endsequence
    ready_after_setup_a: assert property (setup_s |=> pready_out)
        else $error("no ready after setup");
    ready_single_a: assert property (pready_out |=> !pready_out)
        else $error("ready too long");
    ready_cause_a: assert property (pready_out |-> $past(psel_in && !penable_in))
        else $error("ready without setup");
    err_unmapped_a: assert property (setup_s ##0 !mapped |=> pslverr_out)
        else $error("unmapped not refused");
    err_mapped_a: assert property (setup_s ##0 mapped |=> !pslverr_out)
        else $error("mapped refused");
    err_data_zero_a: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
        else $error("refused not clean");
    ctl_upper_zero_a: assert property (pready_out && !pwrite_in && idx == `UTB_IDX_SCTL0 |->
        prdata_out[31:8] == 24'h0)
        else $error("control upper bits set");
    shift_clock_a: assert property ($fell(serial_tx_pin_out[0]) && !serial_rx_pin_oe_n_out[0] |->
        shift_bit_s)
        else $error("bad shift clock");
    shift_data_a: assert property ($rose(serial_tx_pin_out[0]) && !serial_rx_pin_oe_n_out[0] |->
        data_hold_s)
        else $error("shift data moved");
    released_high_a: assert property (serial_rx_pin_oe_n_out[0] |-> serial_rx_pin_out[0])
        else $error("released line low");
endmodule : utb_top_assertions

bind utb_top utb_top_assertions utb_top_assertions_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .serial_rx_pin_out(serial_rx_pin_out), .serial_rx_pin_oe_n_out(serial_rx_pin_oe_n_out),
    .serial_tx_pin_out(serial_tx_pin_out));

// ---- verification/utb_peer.sv ----
// Purpose: Serial peer that checks and sends frames
// Assumes: Bit length in clocks comes from the bench; zero parks the receiver
// Notes: Line idles high as a pulled-up wire would
`timescale 1ns/1ps
module utb_peer (
    input wire logic clk_in,
    input wire logic line_in,
    input wire logic [15:0] bit_len_in,
    input wire logic nine_in,
    output logic line_out,
    output logic [7:0] data_out,
    output logic ninth_out,
    output logic stop_out,
    output logic [7:0] count_out,
    output logic [31:0] gap_out
);
    int cyc = 0, t0, t_end = 0, n;
    logic [9:0] bits;
    always @(posedge clk_in) cyc <= cyc + 1;
    initial begin
        line_out = 1'b1;
        count_out = 8'h00;
        forever begin
            @(posedge clk_in);
            if (bit_len_in != 16'h0000 && line_in === 1'b0) begin
                n = nine_in ? 10 : 9;
                t0 = cyc;
                // Mid-bit sampling tolerates a few clocks of skew
                repeat (bit_len_in / 2) @(posedge clk_in);
                for (int i = 0; i < n; i++) begin
                    repeat (bit_len_in) @(posedge clk_in);
                    bits[i] = line_in;
                end
                data_out = bits[7:0];
                ninth_out = bits[8];
                stop_out = bits[n - 1];
                gap_out = 32'(t0 - t_end);
                t_end = t0 + (n + 1) * bit_len_in;
                count_out = count_out + 8'h01;
            end
        end
    end
    task automatic send_byte(input logic [8:0] val);
        logic [10:0] fr;
        fr = nine_in ? {1'b1, val, 1'b0} : {2'b11, val[7:0], 1'b0};
        for (int i = 0; i < (nine_in ? 11 : 10); i++) begin
            @(posedge clk_in);
            line_out <= fr[i];
            repeat (bit_len_in - 1) @(posedge clk_in);
        end
    endtask : send_byte
endmodule : utb_peer

// ---- verification/tb.sv ----
// Purpose: Register level test of transmit flags, framing and baud sources
// Assumes: One peer model per port
// Notes: Reloads near the top keep frames short
`timescale 1ns/1ps
`include "utb_map.svh"
module tb;
    logic clk_in = 1'b0, reset_n_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [13:0] paddr_in = 14'h0000;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out;
    logic pready_out, pslverr_out;
    wire [1:0] rx_line, dev_rx, oe_n, tx_line, peer_tx;
    logic [15:0] bit_len[2] = '{16'h0000, 16'h0000};
    logic nine[2] = '{1'b0, 1'b0};
    logic [7:0] p_data[2], p_cnt[2];
    logic p_ninth[2], p_stop[2], err;
    logic [31:0] p_gap[2], rd;
    logic [7:0] shift_seen = 8'h00;
    int miscompares = 0, samples_checked = 0;
    logic [11:0] rst_tab[5] = '{`UTB_IDX_TIMER2_CONTROL, `UTB_IDX_TIMER2_MODE, `UTB_IDX_SYSTEM_CONFIG,
        `UTB_IDX_SCTL0, `UTB_IDX_SCTL1};
    logic [15:0] bl_tab[4] = '{16'h0080, 16'h0200, 16'h0800, 16'h0080};
    logic [31:0] sc_tab[4] = '{32'h0, 32'h4, 32'h8, 32'h0};
    logic [31:0] md_tab[4] = '{32'h3, 32'h3, 32'h3, 32'h2};
    logic [31:0] rl_tab[4] = '{32'hfe, 32'hfe, 32'hfe, 32'hfffe};
    always #4 clk_in = ~clk_in;
    utb_top utb_top_inst (.clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .serial_rx_pin_in(rx_line), .serial_rx_pin_out(dev_rx), .serial_rx_pin_oe_n_out(oe_n),
        .serial_tx_pin_out(tx_line));
    for (genvar p = 0; p < 2; p++) begin : g_peer
        assign rx_line[p] = oe_n[p] ? peer_tx[p] : dev_rx[p];
        utb_peer utb_peer_inst (.clk_in(clk_in), .line_in(tx_line[p]), .bit_len_in(bit_len[p]),
            .nine_in(nine[p]), .line_out(peer_tx[p]), .data_out(p_data[p]), .ninth_out(p_ninth[p]),
            .stop_out(p_stop[p]), .count_out(p_cnt[p]), .gap_out(p_gap[p]));
    end
    // Shift data taken on rising shift clock, LSB first
    always @(posedge tx_line[0]) if (oe_n[0] === 1'b0) shift_seen <= {dev_rx[0], shift_seen[7:1]};
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic give_up(input string what);
        check(what, 32'h0, 32'h1);
        report_and_stop();
    endtask : give_up
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
        int n = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= {idx, 2'b00};
        pwdata_in <= wd;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 16);
        if (n >= 16) give_up("apb ready");
        else begin
            rd = prdata_out;
            err = pslverr_out;
            psel_in <= 1'b0;
            penable_in <= 1'b0;
        end
    endtask : apb
    task automatic wait_flag(input logic [11:0] idx, input logic [7:0] mask);
        int n = 0;
        do begin
            apb(1'b0, idx, 32'h0);
            n++;
        end while ((rd[7:0] & mask) !== mask && n < 10000);
        if (n >= 10000) give_up("flag wait");
    endtask : wait_flag
    task automatic wait_frame(input int p, input logic [7:0] cnt);
        int n = 0;
        while (p_cnt[p] !== cnt && n < 30000) begin
            @(posedge clk_in);
            n++;
        end
        if (n >= 30000) give_up("frame wait");
    endtask : wait_frame
    initial begin
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1'b1;
        foreach (rst_tab[i]) begin
            apb(1'b0, rst_tab[i], 32'h0);
            check("reset value", rd, 32'h0);
        end
        apb(1'b0, 12'h000, 32'h0);
        check("unmapped err", err, 32'h1);
        $display("test reset done");
        apb(1'b1, `UTB_IDX_SBUF0, 32'ha5);
        apb(1'b0, `UTB_IDX_SCTL0, 32'h0);
        check("idle write flag", rd, 32'h02);
        apb(1'b1, `UTB_IDX_SCTL0, 32'h00);
        wait_flag(`UTB_IDX_SCTL0, 8'h02);
        check("shift data", shift_seen, 32'ha5);
        $display("test shift mode done");
        bit_len[0] <= 16'h0020;
        nine[0] <= 1'b1;
        apb(1'b1, `UTB_IDX_SCTL0, 32'h88);
        apb(1'b1, `UTB_IDX_SBUF0, 32'ha5);
        apb(1'b0, `UTB_IDX_SCTL0, 32'h0);
        check("idle write flag", rd, 32'h8a);
        apb(1'b1, `UTB_IDX_SCTL0, 32'h88);
        apb(1'b1, `UTB_IDX_SBUF0, 32'h3c);
        apb(1'b0, `UTB_IDX_SCTL0, 32'h0);
        check("busy write flag", rd, 32'h88);
        wait_frame(0, 8'h01);
        check("fixed rate data", p_data[0], 32'ha5);
        check("ninth high", p_ninth[0], 32'h1);
        wait_flag(`UTB_IDX_SCTL0, 8'h02);
        apb(1'b1, `UTB_IDX_SCTL0, 32'h80);
        wait_frame(0, 8'h02);
        check("held data", p_data[0], 32'h3c);
        check("live ninth", p_ninth[0], 32'h0);
        check("no gap", p_gap[0], 32'h0);
        wait_flag(`UTB_IDX_SCTL0, 8'h02);
        $display("test double buffer done");
        nine[0] <= 1'b0;
        apb(1'b1, `UTB_IDX_SCTL0, 32'h50);
        for (int k = 0; k < 4; k++) begin
            bit_len[0] <= bl_tab[k];
            apb(1'b1, `UTB_IDX_T1_MODE, 32'h0);
            apb(1'b1, `UTB_IDX_SYSTEM_CONFIG, sc_tab[k]);
            apb(1'b1, `UTB_IDX_T1_RELOAD, rl_tab[k]);
            apb(1'b1, `UTB_IDX_T1_MODE, md_tab[k]);
            apb(1'b1, `UTB_IDX_SBUF0, 32'h5a);
            wait_frame(0, 8'(3 + k));
            check("timer1 data", p_data[0], 32'h5a);
            check("stop bit", p_stop[0], 32'h1);
        end
        $display("test timer1 baud done");
        g_peer[0].utb_peer_inst.send_byte(9'h0c3);
        wait_flag(`UTB_IDX_SCTL0, 8'h05);
        apb(1'b0, `UTB_IDX_SBUF0, 32'h0);
        check("receive data", rd, 32'hc3);
        $display("test receive done");
        bit_len[1] <= 16'h00c0;
        apb(1'b1, `UTB_IDX_T2_RELOAD, 32'hfffd);
        apb(1'b1, `UTB_IDX_TIMER2_CONTROL, 32'h04);
        apb(1'b1, `UTB_IDX_TIMER2_MODE, 32'h10);
        apb(1'b1, `UTB_IDX_SCTL1, 32'h40);
        apb(1'b1, `UTB_IDX_SBUF1, 32'h96);
        apb(1'b1, `UTB_IDX_SBUF0, 32'h69);
        wait_frame(1, 8'h01);
        check("timer2 data", p_data[1], 32'h96);
        wait_frame(0, 8'h07);
        check("timer1 port data", p_data[0], 32'h69);
        $display("test timer2 baud done");
        report_and_stop();
    end
endmodule : tb
